// File: rtl/imvu_evgate.sv
module imvu_evgate #(
  parameter bit HAS_USB = 1'b1
) (
  // Raw peripheral events, one per source
  input wire logic [17:0] ev_i,
  input wire logic usb_resume_i,
  // Peripheral-level masks
  input wire logic [17:0] pmask_i,
  // Flag set requests
  output logic [17:0] set_o
);

  logic [17:0] ev_all;

  // Resume rides on the port A bit 7 line and is masked like it
  always_comb begin
    ev_all = ev_i;
    ev_all[imvu_pkg::SRC_PORT_A] = ev_i[imvu_pkg::SRC_PORT_A] | (HAS_USB & usb_resume_i);
  end

  // Multi-event sources need their mask bit; the rest pass as they are
  assign set_o = ev_all & (pmask_i | ~imvu_pkg::MULTI_EV);

endmodule : imvu_evgate

// File: rtl/imvu_pkg.sv
package imvu_pkg;

  // Source count and index width
  localparam int NSRC = 18;
  localparam int SRCW = 5;

  // Vector address layout: base plus eight bytes per source
  localparam logic [7:0] VEC_BASE = 8'h03;

  // Source numbers with a fixed meaning
  localparam logic [4:0] SRC_RADIO = 5'h00;
  localparam logic [4:0] SRC_CONV = 5'h01;
  localparam logic [4:0] SRC_SER1_RX = 5'h03;
  localparam logic [4:0] SRC_PORT_C = 5'h06;
  localparam logic [4:0] SRC_PROTO_TMR = 5'h0A;
  localparam logic [4:0] SRC_BYTE_A = 5'h0B;
  localparam logic [4:0] SRC_BYTE_B = 5'h0C;
  localparam logic [4:0] SRC_PORT_A = 5'h0D;
  localparam logic [4:0] SRC_SER1_TX = 5'h0E;
  localparam logic [4:0] SRC_WDOG = 5'h11;

  // Flags cleared by hardware on vectoring: 0,1,2,3,9,10,11,12
  localparam logic [17:0] AUTO_CLR = 18'h0_1E0F;
  // Sources fed by peripherals with several internal events
  localparam logic [17:0] MULTI_EV = 18'h1_BF40;

  // Register byte offsets
  localparam logic [3:0] REG_FLAG = 4'h0;
  localparam logic [3:0] REG_EN = 4'h4;
  localparam logic [3:0] REG_PMASK = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;

  // Field positions inside the flag and enable words
  localparam int BIT_ARX = 18;
  localparam int BIT_ATX = 19;
  localparam int BIT_USB = 20;
  localparam int BIT_GIE = 31;

  // Values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [17:0] RST_SRC18 = 18'h0_0000;

  // Vector address of a source number
  function automatic logic [7:0] vector_of(input logic [4:0] n);
    return VEC_BASE + {n, 3'b000};
  endfunction : vector_of

  // Expand Wishbone byte selects to a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : sel_mask

endpackage : imvu_pkg

// File: rtl/imvu_prio.sv
module imvu_prio (
  // Pending sources, already enabled
  input wire logic [17:0] pend_i,
  // Winner
  output logic any_o,
  output logic [4:0] src_o,
  output logic [7:0] vec_o
);

  // Fixed order: lowest source number wins; grouping is not modelled
  always_comb begin
    src_o = 5'h00;
    for (int i = imvu_pkg::NSRC - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        src_o = i[4:0];
      end
    end
    any_o = |pend_i;
    vec_o = imvu_pkg::vector_of(src_o);
  end

endmodule : imvu_prio

// File: rtl/imvu_top.sv
// How it works
// - Each source has its own CPU enable bit
// - Multi-event sources need a peripheral mask bit
// - Interrupts taken only with global enable set
// - Source n vectors to 0x03 plus eight n
// - Converter done is source 1 at 0x0B
// - Protocol timer overflow is source 10 at 0x53
// - Byte timers are sources 11, 12 at 0x5B, 0x63
// - Watchdog timer mode overflow is source 17, 0x8B
// - Sources 0-3, 9-12 self-clear on vectoring
// - Audio block has its own enable bits
// - Audio receive shares source 3, vector 0x1B
// - Audio transmit shares source 14, vector 0x73
// - USB pending shares source 6, vector 0x33
// - USB resume enters via port A bit 7
// - Global enable low acknowledges no interrupt
// - Audio flags have no extra mask stage
//
// Local design decisions: the address map and the Wishbone interface to the registers.
module imvu_top #(
  parameter bit HAS_USB = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral events, one-cycle pulses
  input wire logic [17:0] periph_ev_i,
  input wire logic audio_rx_irq_i,
  input wire logic audio_tx_irq_i,
  input wire logic usb_ev_i,
  input wire logic usb_resume_i,
  // Core side
  input wire logic int_ack_i,
  output logic irq_o,
  output logic [4:0] irq_src_o,
  output logic [7:0] irq_vec_o
);

  typedef struct packed {
    logic [17:0] flag;
    logic arx_flag;
    logic atx_flag;
    logic usb_flag;
    logic [17:0] en;
    logic arx_en;
    logic atx_en;
    logic usb_en;
    logic gie;
    logic [17:0] pmask;
    logic ack;
    logic [31:0] rdat;
    logic req;
    logic [4:0] src;
    logic [7:0] vec;
  } imvu_state_t;

  imvu_state_t cur_ff;
  imvu_state_t nxt_st;
  logic [17:0] set_c;
  logic [17:0] pend_c;
  logic [17:0] sw_clr_c;
  logic [17:0] hw_clr_c;
  logic [31:0] wmask_c;
  logic [31:0] wval_c;
  logic take_c;
  logic wr_c;
  logic any_c;
  logic [4:0] win_src_c;
  logic [7:0] win_vec_c;

  // Peripheral-level masking ahead of the CPU flags
  imvu_evgate #(
    .HAS_USB(HAS_USB)
  ) u_evgate (
    .ev_i(periph_ev_i),
    .usb_resume_i(usb_resume_i),
    .pmask_i(cur_ff.pmask),
    .set_o(set_c)
  );

  // Enabled requests, aliases folded onto their shared sources
  always_comb begin
    pend_c = cur_ff.flag & cur_ff.en;
    pend_c[imvu_pkg::SRC_SER1_RX] = pend_c[imvu_pkg::SRC_SER1_RX] |
      (cur_ff.arx_flag & cur_ff.arx_en);
    pend_c[imvu_pkg::SRC_SER1_TX] = pend_c[imvu_pkg::SRC_SER1_TX] |
      (cur_ff.atx_flag & cur_ff.atx_en);
    pend_c[imvu_pkg::SRC_PORT_C] = pend_c[imvu_pkg::SRC_PORT_C] |
      (cur_ff.usb_flag & cur_ff.usb_en);
  end

  // Fixed-order winner and its vector
  imvu_prio u_prio (
    .pend_i(pend_c),
    .any_o(any_c),
    .src_o(win_src_c),
    .vec_o(win_vec_c)
  );

  // Bus strobes; a write lands on the edge that raises ack
  assign take_c = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
  assign wr_c = take_c & wb_we_i;
  assign wmask_c = imvu_pkg::sel_mask(wb_sel_i);
  assign wval_c = wb_dat_i & wmask_c;
  assign sw_clr_c = (wr_c && wb_adr_i == imvu_pkg::REG_FLAG) ? wval_c[17:0] :
    imvu_pkg::RST_SRC18;

  // Only the presented source is cleared, and only if it self-clears
  always_comb begin
    hw_clr_c = imvu_pkg::RST_SRC18;
    if (int_ack_i && cur_ff.req) begin
      hw_clr_c[cur_ff.src] = imvu_pkg::AUTO_CLR[cur_ff.src];
    end
  end

  // Next state of the whole block
  always_comb begin
    nxt_st = cur_ff;
    // Set beats clear so an event in the clearing cycle survives
    nxt_st.flag = (cur_ff.flag & ~sw_clr_c & ~hw_clr_c) | set_c;
    nxt_st.arx_flag = (cur_ff.arx_flag & ~(wr_c && wb_adr_i == imvu_pkg::REG_FLAG &&
      wval_c[imvu_pkg::BIT_ARX])) | audio_rx_irq_i;
    nxt_st.atx_flag = (cur_ff.atx_flag & ~(wr_c && wb_adr_i == imvu_pkg::REG_FLAG &&
      wval_c[imvu_pkg::BIT_ATX])) | audio_tx_irq_i;
    nxt_st.usb_flag = HAS_USB & ((cur_ff.usb_flag & ~(wr_c &&
      wb_adr_i == imvu_pkg::REG_FLAG && wval_c[imvu_pkg::BIT_USB])) | usb_ev_i);
    if (wr_c && wb_adr_i == imvu_pkg::REG_EN) begin
      nxt_st.en = (cur_ff.en & ~wmask_c[17:0]) | wval_c[17:0];
      if (wmask_c[imvu_pkg::BIT_ARX]) begin
        nxt_st.arx_en = wb_dat_i[imvu_pkg::BIT_ARX];
      end
      if (wmask_c[imvu_pkg::BIT_ATX]) begin
        nxt_st.atx_en = wb_dat_i[imvu_pkg::BIT_ATX];
      end
      if (wmask_c[imvu_pkg::BIT_USB]) begin
        nxt_st.usb_en = HAS_USB & wb_dat_i[imvu_pkg::BIT_USB];
      end
      if (wmask_c[imvu_pkg::BIT_GIE]) begin
        nxt_st.gie = wb_dat_i[imvu_pkg::BIT_GIE];
      end
    end
    if (wr_c && wb_adr_i == imvu_pkg::REG_PMASK) begin
      nxt_st.pmask = (cur_ff.pmask & ~wmask_c[17:0]) | wval_c[17:0];
    end
    // Read data is captured with the request; unmapped words read zero
    nxt_st.ack = take_c;
    nxt_st.rdat = cur_ff.rdat;
    if (take_c) begin
      case (wb_adr_i)
        imvu_pkg::REG_FLAG: nxt_st.rdat = {11'h000, cur_ff.usb_flag, cur_ff.atx_flag,
          cur_ff.arx_flag, cur_ff.flag};
        imvu_pkg::REG_EN: nxt_st.rdat = {cur_ff.gie, 10'h000, cur_ff.usb_en,
          cur_ff.atx_en, cur_ff.arx_en, cur_ff.en};
        imvu_pkg::REG_PMASK: nxt_st.rdat = {14'h0000, cur_ff.pmask};
        imvu_pkg::REG_STAT: nxt_st.rdat = {16'h0000, cur_ff.req, 2'b00, cur_ff.src,
          cur_ff.vec};
        default: nxt_st.rdat = imvu_pkg::RST_WORD;
      endcase
    end
    // Only the request is gated by the global enable; source and vector follow the winner regardless
    nxt_st.req = cur_ff.gie & any_c;
    nxt_st.src = any_c ? win_src_c : cur_ff.src;
    nxt_st.vec = any_c ? win_vec_c : cur_ff.vec;
  end

  // Single register stage for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
      cur_ff.src <= imvu_pkg::SRC_RADIO;
      cur_ff.vec <= imvu_pkg::VEC_BASE;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = cur_ff.ack;
  assign wb_dat_o = cur_ff.rdat;
  assign irq_o = cur_ff.req;
  assign irq_src_o = cur_ff.src;
  assign irq_vec_o = cur_ff.vec;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Global enable gates every request
  gie_gate_a: assert property (!cur_ff.gie |=> !cur_ff.req)
    else $error("request raised with global enable low");

  // No enabled flag means no request next cycle
  en_gate_a: assert property (pend_c == 18'h0_0000 |=> !cur_ff.req)
    else $error("request raised without an enabled flag");

  // Vector tracks source number
  vec_map_a: assert property (cur_ff.req |-> cur_ff.vec == 8'h03 + {cur_ff.src, 3'b000})
    else $error("vector does not match source");

  // Fixed assignments of named sources
  fixed_vec_a: assert property (cur_ff.req |->
    (cur_ff.src != 5'h01 || cur_ff.vec == 8'h0B) &&
    (cur_ff.src != 5'h0A || cur_ff.vec == 8'h53) &&
    (cur_ff.src != 5'h0B || cur_ff.vec == 8'h5B) &&
    (cur_ff.src != 5'h0C || cur_ff.vec == 8'h63) &&
    (cur_ff.src != 5'h11 || cur_ff.vec == 8'h8B))
    else $error("named source on wrong vector");

  // Masked port A line never raises its flag
  port_mask_a: assert property (!cur_ff.pmask[13] && !cur_ff.flag[13] |=> !cur_ff.flag[13])
    else $error("masked multi-event source set its flag");

  // Self-clearing flag drops on vectoring
  auto_clr_a: assert property (int_ack_i && cur_ff.req && cur_ff.src == 5'h0A &&
    !set_c[10] |=> !cur_ff.flag[10])
    else $error("protocol timer flag not cleared on vectoring");

  // Software-cleared flag survives vectoring
  sw_flag_a: assert property (int_ack_i && cur_ff.req && cur_ff.src == 5'h05 &&
    cur_ff.flag[5] && !sw_clr_c[5] |=> cur_ff.flag[5])
    else $error("sleep timer flag cleared by hardware");

  // Flags hold unless a clear arrives
  sticky_a: assert property (1'b1 |=>
    ($past(cur_ff.flag & ~sw_clr_c & ~hw_clr_c) & ~cur_ff.flag) == 18'h0_0000)
    else $error("flag dropped without a clear");

  // Audio receive lands on source 3
  arx_share_a: assert property (cur_ff.gie && cur_ff.arx_flag && cur_ff.arx_en &&
    pend_c[2:0] == 3'b000 |=> cur_ff.src == 5'h03 && cur_ff.vec == 8'h1B)
    else $error("audio receive not on shared vector");

  // Audio transmit lands on source 14
  atx_share_a: assert property (cur_ff.gie && cur_ff.atx_flag && cur_ff.atx_en &&
    pend_c[13:0] == 14'h0000 |=> cur_ff.src == 5'h0E && cur_ff.vec == 8'h73)
    else $error("audio transmit not on shared vector");

  // USB pending lands on source 6
  usb_share_a: assert property (cur_ff.gie && cur_ff.usb_flag && cur_ff.usb_en &&
    pend_c[5:0] == 6'h00 |=> cur_ff.src == 5'h06 && cur_ff.vec == 8'h33)
    else $error("usb pending not on shared vector");

  // Bus acknowledge is a single-cycle pulse
  ack_pulse_a: assert property (cur_ff.ack |=> !cur_ff.ack)
    else $error("bus acknowledge held longer than one cycle");

  // A taken access is answered on the next edge
  ack_latency_a: assert property (take_c |=> cur_ff.ack)
    else $error("bus access not answered in one cycle");

  // Enabled pending with global enable raises the request
  req_raise_a: assert property (cur_ff.gie && any_c |=> cur_ff.req)
    else $error("enabled pending source not presented");

  // Source 0 always wins when it is pending
  win_lowest_a: assert property (pend_c[0] |=> cur_ff.src == 5'h00)
    else $error("lowest pending source did not win");

  // Masked multi-event sources never request a flag set
  mask_drop_a: assert property ((set_c & imvu_pkg::MULTI_EV & ~cur_ff.pmask) == 18'h0_0000)
    else $error("masked multi-event source requested a set");

  // Audio receive event sets its own flag unmasked
  arx_set_a: assert property (audio_rx_irq_i |=> cur_ff.arx_flag)
    else $error("audio receive event lost");

  // Audio transmit event sets its own flag unmasked
  atx_set_a: assert property (audio_tx_irq_i |=> cur_ff.atx_flag)
    else $error("audio transmit event lost");

  // Radio flag self-clears on vectoring
  radio_clr_a: assert property (int_ack_i && cur_ff.req && cur_ff.src == 5'h00 &&
    !set_c[0] |=> !cur_ff.flag[0])
    else $error("radio flag not cleared on vectoring");

  // Watchdog flag is left for software to clear
  wdog_keep_a: assert property (int_ack_i && cur_ff.req && cur_ff.src == 5'h11 &&
    cur_ff.flag[17] && !sw_clr_c[17] |=> cur_ff.flag[17])
    else $error("watchdog flag cleared by hardware");

  // Without the USB option the pending flag never rises
  usb_absent_a: assert property (HAS_USB || !cur_ff.usb_flag)
    else $error("usb flag set on a variant without usb");

  // Resume reaches the port A source when its mask allows
  resume_path_a: assert property (HAS_USB && usb_resume_i && cur_ff.pmask[13] |=>
    cur_ff.flag[13])
    else $error("usb resume did not reach port A source");

  // Enables only change through a bus write
  en_hold_a: assert property (!wr_c |=> cur_ff.en == $past(cur_ff.en))
    else $error("source enables changed without a write");

  // An event always lands, even against a clear
  set_wins_a: assert property (set_c[2] |=> cur_ff.flag[2])
    else $error("event lost against a clear");

  // Clearing global enable through the bus takes effect
  gie_clear_a: assert property (wr_c && wb_adr_i == imvu_pkg::REG_EN && wb_sel_i[3] &&
    !wb_dat_i[31] |=> !cur_ff.gie)
    else $error("global enable not cleared by write");

  // Main scenarios
  vec_ack_c: cover property (cur_ff.req && int_ack_i && imvu_pkg::AUTO_CLR[cur_ff.src]);
  audio_rx_c: cover property (cur_ff.req && cur_ff.arx_flag && cur_ff.src == 5'h03);
  usb_pend_c: cover property (cur_ff.req && cur_ff.usb_flag && cur_ff.src == 5'h06);
  wdog_c: cover property (cur_ff.req && cur_ff.src == 5'h11);

endmodule : imvu_top

// File: test/imvu_core_model.sv
module imvu_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the controller
  input wire logic irq_i,
  input wire logic [4:0] src_i,
  // Bench controls: accept requests, decode delay
  input wire logic en_i,
  input wire logic [1:0] wait_i,
  // Acknowledge pulse and what was taken
  output logic ack_o,
  output logic [4:0] taken_o,
  output int count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  // Vector after a short or long decode delay; the ack is one cycle, but with wait_i zero
  // and en_i held a source that self-clears is taken again, as irq_i lags the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 0;
      count_o <= 0;
      taken_o <= 5'h00;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      cnt <= 0;
    end else if (en_i && irq_i) begin
      cnt <= cnt + 1;
      if (cnt >= int'(wait_i)) begin
        ack_o <= 1'b1;
        taken_o <= src_i;
        count_o <= count_o + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule : imvu_core_model

// File: test/imvu_top_test.sv
module imvu_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic iack;
  logic core_en = 1'b0;
  logic [1:0] dly = 2'h0;
  logic [21:0] evs = 22'h00_0000;
  logic [4:0] src;
  logic [4:0] taken;
  logic [7:0] vec;
  logic [31:0] seed = 32'h258a_b568;
  int acks;
  int fail_count = 0;
  int checked = 0;
  int exp_q[$];

  // Clock at 20 MHz
  initial forever #25 clk_i = ~clk_i;

  imvu_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .periph_ev_i(evs[17:0]), .audio_rx_irq_i(evs[18]), .audio_tx_irq_i(evs[19]),
    .usb_ev_i(evs[20]), .usb_resume_i(evs[21]), .int_ack_i(iack), .irq_o(irq),
    .irq_src_o(src), .irq_vec_o(vec));

  imvu_core_model core (
    .clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .src_i(src), .en_i(core_en),
    .wait_i(dly), .ack_o(iack), .taken_o(taken), .count_o(acks));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; the bench timeout ends a wait, not a cycle count
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Event pulses, one cycle wide: {resume, usb, audio tx, audio rx, sources}
  task automatic pulse(input logic [21:0] p);
    @(posedge clk_i);
    evs <= p;
    @(posedge clk_i);
    evs <= 22'h00_0000;
  endtask : pulse

  // Clear, enable the source, then globally, raise the event, let the core vector
  task automatic run_src(input int n, input logic [21:0] p, input int b);
    int c0;
    int k;
    wb(1'b1, 4'h0, 32'hffff_ffff);
    wb(1'b1, 4'h4, 32'(1) << b);
    wb(1'b1, 4'h4, (32'(1) << b) | 32'h8000_0000);
    seed = xs(seed);
    dly <= seed[1:0];
    core_en <= 1'b1;
    exp_q.push_back(n);
    c0 = acks;
    pulse(p);
    k = 0;
    while (acks == c0 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    core_en <= 1'b0;
    chk("source", 32'(exp_q.pop_front()), 32'(taken));
    chk("vector", 32'(3 + 8 * n), 32'(vec));
    wb(1'b0, 4'h0, 32'h0000_0000);
    k = (b == n && (n < 4 || (n > 8 && n < 13))) ? 0 : 1;
    chk("flag", 32'(k), 32'(rdat[b]));
  endtask : run_src

  // An event that must not reach the core; the flag may or may not stay
  task automatic quiet(input logic [31:0] en, input logic [21:0] p, input int b, input int f);
    wb(1'b1, 4'h0, 32'hffff_ffff);
    wb(1'b1, 4'h4, en);
    pulse(p);
    repeat (6) @(posedge clk_i);
    chk("irq", 32'h0000_0000, 32'(irq));
    wb(1'b0, 4'h0, 32'h0000_0000);
    chk("pending", 32'(f), 32'(rdat[b]));
  endtask : quiet

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("vec_rst", 32'h0000_0003, 32'(vec));
    wb(1'b0, 4'hc, 32'h0000_0000);
    chk("stat_rst", 32'h0000_0003, rdat);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk("en_rst", 32'h0000_0000, rdat);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rdat);
    seed = xs(seed);
    wb(1'b1, 4'h8, seed & 32'h0003_ffff);
    wb(1'b0, 4'h8, 32'h0000_0000);
    chk("pmask", seed & 32'h0003_ffff, rdat);
    wb(1'b1, 4'h8, 32'h0000_0000);
    quiet(32'h8000_0400, 22'h00_0400, 10, 0);
    run_src(3, 22'h04_0000, 18);
    run_src(14, 22'h08_0000, 19);
    wb(1'b1, 4'h8, 32'h0003_ffff);
    quiet(32'h8000_0000, 22'h00_0080, 7, 1);
    quiet(32'h0000_0020, 22'h00_0020, 5, 1);
    for (int i = 0; i < 18; i++) run_src(i, 22'(1) << i, i);
    run_src(6, 22'h10_0000, 20);
    run_src(13, 22'h20_0000, 13);
    complete_run();
  end

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
endmodule : imvu_top_test
